/* logic/rsfs_pkg.sv */
// Purpose: Shared constants and types for the rail sequencing fault supervisor
// Assumes: core_clk at 50 MHz, synchronous active-low reset
// Notes:   Register offsets are word indices on the plain register port
package rsfs_pkg;
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned TICK_US       = 1;
   localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned PG_DELAY_US   = 2000;
   localparam int unsigned OC_TRIP_COUNT = 7;
   localparam int unsigned HICCUP_MULT   = 7;
   localparam int unsigned JT_SHDN_DEGC  = 160;
   localparam int unsigned JT_RSTR_DEGC  = 140;

   localparam logic [3:0] ADR_ONOFF_CFG = 4'h0;
   localparam logic [3:0] ADR_OPERATION = 4'h1;
   localparam logic [3:0] ADR_TON_DLY   = 4'h2;
   localparam logic [3:0] ADR_TON_RISE  = 4'h3;
   localparam logic [3:0] ADR_TOFF_DLY  = 4'h4;
   localparam logic [3:0] ADR_MISC_CFG  = 4'h5;
   localparam logic [3:0] ADR_STATE     = 4'h6;
   localparam logic [3:0] ADR_IRQ_STAT  = 4'h7;
   localparam logic [3:0] ADR_IRQ_MASK  = 4'h8;

   // On/off config field layout per rail byte
   localparam int unsigned ONOFF_USE_PIN = 0;
   localparam int unsigned ONOFF_USE_CMD = 1;
   localparam logic [7:0]  ONOFF_RST     = 8'h03;
   // Misc config bits
   localparam int unsigned MISC_RESTART  = 0;
   localparam int unsigned MISC_PGDLY_EN = 1;
   localparam logic [7:0]  MISC_RST      = 8'h03;
   localparam logic [15:0] TIME_RST      = 16'h0000;
   localparam logic [15:0] RISE_RST      = 16'h0bb8;

   typedef enum logic [1:0] {
      RSFS_MODE_DUAL,
      RSFS_MODE_TWO_PHASE,
      RSFS_MODE_MULTI_MASTER,
      RSFS_MODE_MULTI_SLAVE
   } rsfs_mode_t;

   typedef struct packed {
      logic oc;
      logic uv_in;
      logic uv_out;
      logic ov_out;
      logic mos_ot;
      logic in_window;
   } rsfs_sense_t;

   typedef struct packed {
      logic hs_on;
      logic ls_on;
      logic pg;
   } rsfs_drive_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } rsfs_bus_t;
endpackage

/* logic/rsfs_rail.sv */
// Purpose: One rail sequencer with fault handling
// Assumes: Sense inputs synchronous to core_clk; tick is a 1 us enable
// Notes:   Times are in microsecond ticks
`timescale 1ns/1ps
module rsfs_rail
   import rsfs_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        tick,
   input  wire logic        start_ok,
   input  wire logic        is_slave,
   input  wire logic        restart_en,
   input  wire logic        pg_dly_en,
   input  wire logic        jt_hot,
   input  wire logic        fault_ext,
   input  wire logic [15:0] ton_dly,
   input  wire logic [15:0] ton_rise,
   input  wire logic [15:0] toff_dly,
   input  wire rsfs_sense_t sense,
   output rsfs_drive_t      drive,
   output logic             fault_pull,
   output logic             on_evt,
   output logic             flt_evt,
   output logic [2:0]       state_code
);
   typedef enum logic [2:0] {
      RS_OFF, RS_DLY, RS_RISE, RS_ON, RS_TOFF, RS_FLT, RS_OVL
   } rsfs_rstate_t;

   rsfs_rstate_t state_r;
   logic [18:0]  cnt_r;
   logic [2:0]   oc_r;
   logic [11:0]  pgc_r;
   logic         mos_hot_r;
   logic         pg_r;
   logic         own_flt;
   logic         ss_done;

   assign ss_done = (state_r == RS_ON);
   // Output UV ignored until soft-start ends; slaves skip output
   assign own_flt = sense.uv_in | (ss_done & ~is_slave & sense.uv_out)
                  | sense.mos_ot | (oc_r == 3'(OC_TRIP_COUNT - 1) & sense.oc & ss_done);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         oc_r <= '0;
      end else if (!ss_done || !sense.oc) begin
         oc_r <= '0;                                  // Cycle-by-cycle only in soft-start
      end else if (tick && oc_r != 3'(OC_TRIP_COUNT - 1)) begin
         oc_r <= oc_r + 3'd1;                          // Consecutive OC counts
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mos_hot_r <= 1'b0;
      end else if (sense.mos_ot) begin
         mos_hot_r <= 1'b1;                            // Restart waits for hysteresis
      end else if (tick) begin
         mos_hot_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_r <= RS_OFF;
         cnt_r   <= '0;
      end else begin
         unique case (state_r)
            RS_OFF: begin
               if (start_ok && !fault_ext && !jt_hot && !mos_hot_r) begin
                  state_r <= RS_DLY;
                  cnt_r   <= {3'd0, ton_dly};
               end
            end
            RS_DLY, RS_RISE: begin
               if (sense.ov_out && !is_slave) begin
                  state_r <= RS_OVL;                 // Fixed OV acts in delay, rise, on and turn-off on masters
               end else if (jt_hot || fault_ext || own_flt) begin
                  state_r <= RS_FLT;
                  cnt_r   <= 19'(ton_rise) * 19'(HICCUP_MULT);
               end else if (!start_ok) begin
                  state_r <= RS_OFF;
               end else if (cnt_r == '0) begin
                  state_r <= (state_r == RS_DLY) ? RS_RISE : RS_ON;
                  cnt_r   <= {3'd0, ton_rise};
               end else if (tick) begin
                  cnt_r <= cnt_r - 19'd1;
               end
            end
            RS_ON: begin
               if (sense.ov_out && !is_slave) begin
                  state_r <= RS_OVL;
               end else if (jt_hot || fault_ext || own_flt) begin
                  state_r <= RS_FLT;
                  cnt_r   <= 19'(ton_rise) * 19'(HICCUP_MULT);
               end else if (!start_ok) begin
                  state_r <= RS_TOFF;
                  cnt_r   <= {3'd0, toff_dly};
               end
            end
            RS_TOFF: begin
               // New turn-on ignored until delay expires and output is off
               if (sense.ov_out && !is_slave) begin
                  state_r <= RS_OVL;
               end else if (jt_hot || fault_ext || own_flt) begin
                  state_r <= RS_FLT;
                  cnt_r   <= 19'(ton_rise) * 19'(HICCUP_MULT);
               end else if (cnt_r == '0) begin
                  state_r <= RS_OFF;
               end else if (tick) begin
                  cnt_r <= cnt_r - 19'd1;
               end
            end
            RS_FLT: begin
               // Hiccup restart only after every phase frees the shared line
               if (cnt_r != '0) begin
                  if (tick) begin
                     cnt_r <= cnt_r - 19'd1;
                  end
               end else if (!start_ok) begin
                  state_r <= RS_OFF;
               end else if (restart_en && !fault_ext && !jt_hot && !mos_hot_r) begin
                  state_r <= RS_OFF;
               end
            end
            RS_OVL: begin
               if (!start_ok) begin
                  state_r <= RS_OFF;                 // Cleared by pin or command toggle
               end
            end
            default: state_r <= RS_OFF;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pgc_r <= '0;
         pg_r  <= 1'b0;
      end else if (!ss_done || !sense.in_window) begin
         pgc_r <= '0;
         pg_r  <= 1'b0;                              // Drops at once out of window
      end else if (!pg_dly_en || pgc_r == 12'(PG_DELAY_US)) begin
         pg_r  <= 1'b1;
      end else if (tick) begin
         pgc_r <= pgc_r + 12'd1;
      end
   end

   assign drive.hs_on = (state_r == RS_RISE) || (state_r == RS_ON) || (state_r == RS_TOFF);
   assign drive.ls_on = drive.hs_on || (state_r == RS_OVL);
   assign drive.pg    = pg_r;
   assign fault_pull  = (state_r == RS_FLT) && (own_flt || cnt_r != '0);
   assign on_evt      = (state_r == RS_RISE) && (cnt_r == '0);
   assign flt_evt     = (state_r != RS_FLT) && (state_r != RS_OVL) && (state_r != RS_OFF)
                      && (jt_hot || fault_ext || own_flt || sense.ov_out);
   assign state_code  = state_r;
endmodule // rsfs_rail

/* logic/rsfs_top.sv */
// Purpose: Two-rail sequencing and fault supervisor with register port
// Assumes: All inputs synchronous to core_clk
// Notes:   Shared fault lines are open drain, three signals each
`timescale 1ns/1ps
module rsfs_top
   import rsfs_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire rsfs_bus_t        bus,
   output logic [15:0]           rdata,
   input  wire logic [1:0]       rail_control_pin,
   input  wire logic [7:0]       junction_temp,
   input  wire rsfs_mode_t       phase_mode,
   input  wire rsfs_sense_t [1:0] sense,
   input  wire logic [1:0]       shared_fault_line_i,
   output logic [1:0]            shared_fault_line_o,
   output logic [1:0]            shared_fault_line_oe,
   output rsfs_drive_t [1:0]     drive,
   output logic [1:0]            output_in_window_flag,
   output logic                  junction_overtemp_fault,
   output logic                  irq
);
   logic [15:0] onoff_r;
   logic [1:0]  oper_r;
   logic [15:0] ton_dly_r  [2];
   logic [15:0] ton_rise_r [2];
   logic [15:0] toff_dly_r [2];
   logic [7:0]  misc_r;
   logic [5:0]  irq_stat_r;
   logic [5:0]  irq_mask_r;
   logic [5:0]  irq_set;
   logic [5:0]  tick_r;
   logic        tick;
   logic        jt_hot_r;
   logic [1:0]  pull;
   logic [1:0]  on_evt;
   logic [1:0]  flt_evt;
   logic [2:0]  st [2];
   logic [1:0]  slave;
   logic        rd_stat;

   function automatic logic hit(input rsfs_bus_t b, input logic [3:0] a);
      hit = b.wr && (b.addr == a);
   endfunction

   always_ff @(posedge core_clk) begin
      if (!rst_n || tick_r == 6'(TICK_CYC - 1)) begin
         tick_r <= '0;
      end else begin
         tick_r <= tick_r + 6'd1;
      end
   end
   assign tick = (tick_r == 6'(TICK_CYC - 1));

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         jt_hot_r <= 1'b0;
      end else if (junction_temp >= 8'(JT_SHDN_DEGC)) begin
         jt_hot_r <= 1'b1;                           // PWM off when hot
      end else if (junction_temp <= 8'(JT_RSTR_DEGC)) begin
         jt_hot_r <= 1'b0;                           // Soft-start again when cool
      end
   end
   assign junction_overtemp_fault = jt_hot_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         onoff_r <= {ONOFF_RST, ONOFF_RST};
         oper_r  <= 2'b00;
         misc_r  <= MISC_RST;
         irq_mask_r <= '0;
      end else begin
         if (hit(bus, ADR_ONOFF_CFG)) onoff_r <= bus.wdata;
         if (hit(bus, ADR_OPERATION)) oper_r <= bus.wdata[1:0];
         if (hit(bus, ADR_MISC_CFG)) misc_r <= bus.wdata[7:0];
         if (hit(bus, ADR_IRQ_MASK)) irq_mask_r <= bus.wdata[5:0];
      end
   end

   // Writes set both rails alike, since multi-phase needs matched timing
   for (genvar i = 0; i < 2; i++) begin : g_time
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            ton_dly_r[i]  <= TIME_RST;
            ton_rise_r[i] <= RISE_RST;
            toff_dly_r[i] <= TIME_RST;
         end else begin
            if (hit(bus, ADR_TON_DLY)) ton_dly_r[i] <= bus.wdata;
            if (hit(bus, ADR_TON_RISE)) ton_rise_r[i] <= bus.wdata;
            if (hit(bus, ADR_TOFF_DLY)) toff_dly_r[i] <= bus.wdata;
         end
      end
   end

   // Channel roles per mode; only in two-phase mode does the slave follow channel 1's enable and settings
   assign slave[0] = (phase_mode == RSFS_MODE_MULTI_SLAVE);
   assign slave[1] = (phase_mode != RSFS_MODE_DUAL);

   for (genvar i = 0; i < 2; i++) begin : g_rail
      logic [7:0] cfg;
      logic       start_ok;
      int unsigned src;
      assign src = (phase_mode == RSFS_MODE_TWO_PHASE && i == 1) ? 0 : i;
      assign cfg = onoff_r[8*src +: 8];
      assign start_ok = ~sense[i].uv_in
                      & (~cfg[ONOFF_USE_PIN] | rail_control_pin[src])
                      & (~cfg[ONOFF_USE_CMD] | oper_r[src]);

      rsfs_rail u_rail (
         .core_clk   (core_clk),
         .rst_n      (rst_n),
         .tick       (tick),
         .start_ok   (start_ok),
         .is_slave   (slave[i]),
         .restart_en (misc_r[MISC_RESTART]),
         .pg_dly_en  (misc_r[MISC_PGDLY_EN]),
         .jt_hot     (jt_hot_r),
         .fault_ext  (~shared_fault_line_i[i]),
         .ton_dly    (ton_dly_r[i]),
         .ton_rise   (ton_rise_r[i]),
         .toff_dly   (toff_dly_r[i]),
         .sense      (sense[i]),
         .drive      (drive[i]),
         .fault_pull (pull[i]),
         .on_evt     (on_evt[i]),
         .flt_evt    (flt_evt[i]),
         .state_code (st[i])
      );
      assign shared_fault_line_o[i]  = 1'b0;
      assign shared_fault_line_oe[i] = pull[i];
      assign output_in_window_flag[i] = drive[i].pg;
   end

   assign irq_set = {jt_hot_r, 1'b0, flt_evt, on_evt};
   assign rd_stat = bus.rd && (bus.addr == ADR_IRQ_STAT);

   // Set wins over the read-clear so no event is lost
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (rd_stat ? 6'd0 : irq_stat_r) | irq_set;
      end
   end
   assign irq = |(irq_stat_r & irq_mask_r);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (bus.rd) begin
         unique case (bus.addr)
            ADR_ONOFF_CFG: rdata <= onoff_r;
            ADR_OPERATION: rdata <= {14'd0, oper_r};
            ADR_TON_DLY:   rdata <= ton_dly_r[0];
            ADR_TON_RISE:  rdata <= ton_rise_r[0];
            ADR_TOFF_DLY:  rdata <= toff_dly_r[0];
            ADR_MISC_CFG:  rdata <= {8'd0, misc_r};
            ADR_STATE:     rdata <= {7'd0, jt_hot_r, 2'd0, st[1], st[0]};
            ADR_IRQ_STAT:  rdata <= {10'd0, irq_stat_r};
            ADR_IRQ_MASK:  rdata <= {10'd0, irq_mask_r};
            default:       rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end
endmodule // rsfs_top

/* dv/rsfs_peer.sv */
// Purpose: Peer phase controllers sharing the fault nets
// Assumes: Nets are pulled up and any party may pull low
// Notes:   When the peer pulls is commanded by the bench
`timescale 1ns/1ps
module rsfs_peer (
   input  wire logic [1:0] peer_pull,
   input  wire logic [1:0] dut_oe,
   input  wire logic [1:0] dut_o,
   output logic [1:0]      fault_wire
);
   // A released net goes to the pull-up, never keeps the last driven level
   assign fault_wire = ~peer_pull & (~dut_oe | dut_o);
endmodule // rsfs_peer

/* dv/rsfs_chk.sv */
// Purpose: Port assertions for rsfs_top
// Assumes: One clock, synchronous active-low reset
// Notes:   Rail 0 is watched; rail 1 shares its logic
`timescale 1ns/1ps
module rsfs_chk
   import rsfs_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              rst_n,
   input wire logic [7:0]        junction_temp,
   input wire rsfs_sense_t [1:0] sense,
   input wire logic [1:0]        shared_fault_line_i,
   input wire logic [1:0]        shared_fault_line_oe,
   input wire rsfs_drive_t [1:0] drive,
   input wire logic [1:0]        output_in_window_flag,
   input wire logic              junction_overtemp_fault
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   chk_uv_blocks: assert property (
      sense[0].uv_in && !drive[0].hs_on && !drive[0].ls_on |=> !drive[0].hs_on)
      else $error("rail started under input undervoltage");
   chk_own_pull: assert property (
      $rose(sense[0].mos_ot) && drive[0].hs_on |-> ##[1:3] shared_fault_line_oe[0])
      else $error("own fault left the fault line released");
   chk_mos_off: assert property (
      $rose(sense[0].mos_ot) && drive[0].hs_on |-> ##[1:3] !(drive[0].hs_on || drive[0].ls_on))
      else $error("switches kept on at switch overtemperature");
   chk_ext_off: assert property (
      !shared_fault_line_i[0] && !shared_fault_line_oe[0]
      |-> ##[1:2] !(drive[0].hs_on || drive[0].ls_on))
      else $error("external fault pull did not stop the rail");
   chk_ov_latch: assert property (
      $rose(sense[0].ov_out) && drive[0].hs_on |-> ##[1:2] (!drive[0].hs_on && drive[0].ls_on))
      else $error("overvoltage response wrong");
   chk_jt_set: assert property (
      junction_temp >= 8'ha0 |=> junction_overtemp_fault)
      else $error("junction shutdown flag missing");
   chk_jt_clear: assert property (
      junction_temp <= 8'h8c |=> !junction_overtemp_fault)
      else $error("junction shutdown flag stuck");
   chk_pg_drop: assert property (
      !sense[0].in_window |=> !output_in_window_flag[0])
      else $error("power good kept outside window");
endmodule // rsfs_chk

bind rsfs_top rsfs_chk u_rsfs_chk (
   .core_clk(core_clk), .rst_n(rst_n), .junction_temp(junction_temp), .sense(sense),
   .shared_fault_line_i(shared_fault_line_i), .shared_fault_line_oe(shared_fault_line_oe),
   .drive(drive), .output_in_window_flag(output_in_window_flag),
   .junction_overtemp_fault(junction_overtemp_fault));

/* dv/tb.sv */
// Purpose: Self-checking bench for rsfs_top
// Assumes: 1 us tick, short delays programmed by the bench
// Notes:   The 2 ms good delay is turned off; it would dominate run time
`timescale 1ns/1ps
module tb;
   import rsfs_pkg::*;
   logic              core_clk;
   logic              rst_n;
   rsfs_bus_t         bus;
   logic [15:0]       rdata;
   logic [1:0]        pin;
   logic [7:0]        jt;
   rsfs_sense_t [1:0] sense;
   logic [1:0]        fl_w;
   logic [1:0]        fl_o;
   logic [1:0]        fl_oe;
   logic [1:0]        pg;
   logic [1:0]        pull;
   rsfs_drive_t [1:0] drive;
   logic              jhot;
   logic              irq;
   rsfs_mode_t        mode;
   int                err_total;
   int                checks_done;
   int                n;

   rsfs_top u_rsfs_top (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .rail_control_pin(pin), .junction_temp(jt), .phase_mode(mode),
      .sense(sense), .shared_fault_line_i(fl_w), .shared_fault_line_o(fl_o),
      .shared_fault_line_oe(fl_oe), .drive(drive), .output_in_window_flag(pg),
      .junction_overtemp_fault(jhot), .irq(irq));
   rsfs_peer u_rsfs_peer (.peer_pull(pull), .dut_oe(fl_oe), .dut_o(fl_o), .fault_wire(fl_w));

   always #10 core_clk = ~core_clk;

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rc(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 cmp(rdata, e);
      @(posedge core_clk);
   endtask
   // Pin vector {hs, ls, fault pull, good, junction hot, irq} under a mask
   task automatic ckd(input int r, input logic [5:0] e, input logic [5:0] m);
      #1 cmp(16'({drive[r].hs_on, drive[r].ls_on, fl_oe[r], pg[r], jhot, irq} & m), 16'(e));
      @(posedge core_clk);
   endtask
   task automatic wait_hs(input int r, input logic v, input int lim);
      n = 0;
      while (drive[r].hs_on !== v) begin
         @(posedge core_clk);
         n++;
         if (n > lim) begin
            err_total++;
            $display("Error at %0t: switch wait timed out", $time);
            give_verdict();
         end
      end
   endtask

   initial begin
      core_clk = 1'b0;
      mode = RSFS_MODE_DUAL;
      rst_n = 1'b0;
      bus = '0;
      pin = 2'b10;
      jt = 8'h19;
      sense = '0;
      sense[0].uv_in = 1'b1;
      sense[0].in_window = 1'b1;
      pull = 2'b00;
      err_total = 0;
      checks_done = 0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      rc(ADR_ONOFF_CFG, {ONOFF_RST, ONOFF_RST});
      rc(ADR_MISC_CFG, {8'h00, MISC_RST});
      rc(ADR_TON_RISE, RISE_RST);
      rc(ADR_TOFF_DLY, TIME_RST);
      wr(4'hf, 16'hffff);
      rc(4'hf, 16'h0000);
      wr(ADR_TON_DLY, 16'h0004);
      wr(ADR_TON_RISE, 16'h0004);
      wr(ADR_TOFF_DLY, 16'h0004);
      wr(ADR_MISC_CFG, 16'h0001);
      wr(ADR_IRQ_MASK, 16'h0001);
      rc(ADR_TON_DLY, 16'h0004);
      wr(ADR_OPERATION, 16'h0001);
      idle(300);
      rc(ADR_STATE, 16'h0000);
      pin <= 2'b11;
      idle(300);
      rc(ADR_STATE, 16'h0000);
      sense[0].uv_in <= 1'b0;
      wait_hs(0, 1'b1, 1000);
      cmp(16'(n inside {[150:260]}), 16'h0001);
      sense[0].uv_out <= 1'b1;
      idle(20);
      rc(ADR_STATE, 16'h0002);
      sense[0].uv_out <= 1'b0;
      idle(300);
      rc(ADR_STATE, 16'h0003);
      ckd(0, 6'b110101, 6'h3f);
      ckd(1, 6'b000000, 6'h3e);
      rc(ADR_IRQ_STAT, 16'h0001);
      ckd(0, 6'b000000, 6'h01);
      // Turn-on request inside the turn-off delay must not restart early
      wr(ADR_OPERATION, 16'h0000);
      idle(60);
      rc(ADR_STATE, 16'h0004);
      ckd(0, 6'b110000, 6'h30);
      wr(ADR_OPERATION, 16'h0001);
      rc(ADR_STATE, 16'h0004);
      wait_hs(0, 1'b0, 400);
      wait_hs(0, 1'b1, 1000);
      cmp(16'(n >= 140), 16'h0001);
      idle(300);
      rc(ADR_IRQ_STAT, 16'h0001);
      wr(ADR_IRQ_MASK, 16'h0004);
      sense[0].uv_out <= 1'b1;
      idle(4);
      ckd(0, 6'b001001, 6'h3f);
      rc(ADR_IRQ_STAT, 16'h0004);
      sense[0].uv_out <= 1'b0;
      pull[0] <= 1'b1;
      idle(2500);
      ckd(0, 6'b000000, 6'h38);
      pull[0] <= 1'b0;
      wait_hs(0, 1'b1, 1000);
      idle(300);
      pull[0] <= 1'b1;
      idle(3);
      ckd(0, 6'b000000, 6'h30);
      pull[0] <= 1'b0;
      wait_hs(0, 1'b1, 3000);
      idle(300);
      sense[0].oc <= 1'b1;
      idle(250);
      rc(ADR_STATE, 16'h0003);
      idle(150);
      rc(ADR_STATE, 16'h0005);
      sense[0].oc <= 1'b0;
      wait_hs(0, 1'b1, 3000);
      idle(300);
      sense[0].ov_out <= 1'b1;
      idle(3);
      ckd(0, 6'b010000, 6'h38);
      sense[0].ov_out <= 1'b0;
      idle(200);
      rc(ADR_STATE, 16'h0006);
      wr(ADR_OPERATION, 16'h0000);
      idle(3);
      ckd(0, 6'b000000, 6'h30);
      wr(ADR_OPERATION, 16'h0001);
      wait_hs(0, 1'b1, 1000);
      idle(300);
      sense[0].in_window <= 1'b0;
      idle(2);
      ckd(0, 6'b110000, 6'h34);
      sense[0].in_window <= 1'b1;
      sense[0].mos_ot <= 1'b1;
      idle(3);
      ckd(0, 6'b001000, 6'h38);
      idle(2000);
      ckd(0, 6'b000000, 6'h30);
      sense[0].mos_ot <= 1'b0;
      wait_hs(0, 1'b1, 1000);
      idle(300);
      jt <= 8'h9f;
      idle(3);
      ckd(0, 6'b110000, 6'h32);
      jt <= 8'ha0;
      idle(3);
      ckd(0, 6'b000010, 6'h32);
      jt <= 8'h8d;
      idle(100);
      ckd(0, 6'b000010, 6'h32);
      jt <= 8'h8c;
      wait_hs(0, 1'b1, 3000);
      // Two-phase: channel 2 follows channel 1's enable as a slave
      wr(ADR_OPERATION, 16'h0000);
      wait_hs(0, 1'b0, 10);
      mode <= RSFS_MODE_TWO_PHASE;
      wr(ADR_OPERATION, 16'h0001);
      wait_hs(1, 1'b1, 1000);
      idle(300);
      rc(ADR_STATE, 16'h001b);
      rc(ADR_IRQ_STAT, 16'h0027);
      cmp(16'(fl_o), 16'h0000);
      give_verdict();
   end
endmodule // tb
